// File: rtl/host_controller_control.sv
// Host controller control register, bits 23..0, with set/clear aliases
//
// Overview of operation
// (RULE1) Software sets enhancement enable only while permission and link enable are 1.
// (RULE2) With permission 0, software leaves PHY enhancements and enhancement enable alone.
// (RULE3) Reserved bits 21 and 20 read as zero.
// (RULE4) Link power status 1 allows link-to-PHY traffic; 0 blocks it.
// (RULE5) PHY-domain access while the PHY clock is stopped ends in target abort.
// (RULE6) With abort disable set, such accesses answer all-ones data instead.
// (RULE7) Offsets DCh..F0h and 100h..11Ch belong to the PHY clock domain.
// (RULE8) Software waits about 10 ms after setting power status before accesses.
// (RULE9) Posted writes accepted only while posted-write enable is 1.
// (RULE10) Software changes posted-write enable only while link enable is 0.
// (RULE11) Link enable clears on hardware reset or software reset.
// (RULE12) Software sets link enable when ready, then forces a bus reset.
// (RULE13) Link enable 0 disconnects the node: no receive, process or transmit.
// (RULE14) Software reset clears internal state, flushes FIFOs, restores register defaults.
// (RULE15) Software reset leaves host configuration space registers untouched.
// (RULE16) Software reset bit reads 1 during the reset, then clears itself.
// (RULE17) Reserved bits 15..0 read as zero.
// (RULE18) Some bits clear only on the global reset input.
// (RULE19) Register has a set address and a clear address.
// (RULE20) Programming permission bit is read-only, loaded from serial memory, default 1.
// (RULE21) A written 1 acts, a written 0 does nothing; both aliases read the value.
`timescale 1ns/1ns
`default_nettype none
module host_controller_control #(
    parameter int SOFT_RESET_CYCLES = hc_control_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic                             clk,
    input  wire logic                             reset,
    input  wire logic                             global_reset_input,
    input  wire logic [hc_control_pkg::ADDR_W-1:0] host_addr,
    input  wire logic                             host_wr,
    input  wire logic                             host_rd,
    input  wire logic [31:0]                      host_wdata,
    output logic      [31:0]                      host_rdata,
    output logic                                  host_rd_valid,
    output logic                                  host_target_abort,
    input  wire logic                             abort_disable,
    input  wire logic                             phy_clock_running,
    input  wire logic                             permission_load,
    input  wire logic                             permission_value,
    input  wire logic                             posted_write_request,
    output logic                                  posted_write_accept,
    output logic                                  phy_program_permission,
    output logic                                  enhancement_enable,
    output logic                                  link_power_status,
    output logic                                  link_phy_comm_enable,
    output logic                                  posted_write_enable_a,
    output logic                                  link_enable_b,
    output logic                                  bus_connected,
    output logic                                  software_reset,
    output logic                                  internal_state_reset,
    output logic                                  fifo_flush
);
    import hc_control_pkg::*;

    // ************************************************************
    // Local signals
    // ************************************************************
    logic        hit_set;
    logic        hit_clr;
    logic        set_wr;
    logic        clr_wr;
    logic        in_phy_domain;
    logic        stopped_abort;
    logic        stopped_ones;
    logic        sw_reset_start;
    logic        sw_reset_busy;
    logic        regs_reset;
    logic [31:0] ctrl_value;
    logic [31:0] read_next;
    logic        enhance_next;
    logic        power_next;
    logic        posted_next;
    logic        link_next;

    // ************************************************************
    // Address decode
    // ************************************************************
    // (RULE19) set and clear aliases
    assign hit_set = (host_addr == CTRL_SET_OFFSET);
    assign hit_clr = (host_addr == CTRL_CLR_OFFSET);

    // Writes are dropped while a software reset runs, so the defaults
    // stand cleanly once the busy window ends.
    assign set_wr = host_wr && hit_set && !sw_reset_busy;
    assign clr_wr = host_wr && hit_clr && !sw_reset_busy;

    // ************************************************************
    // Stopped PHY clock handling
    // ************************************************************
    // (RULE7) PHY domain ranges
    phy_domain_guard u_guard (
        .addr              (host_addr),
        .phy_clock_running (phy_clock_running),
        .abort_disable     (abort_disable),
        .in_phy_domain     (in_phy_domain),
        .stopped_abort     (stopped_abort),
        .stopped_ones      (stopped_ones)
    );

    // ************************************************************
    // Software reset
    // ************************************************************
    // (RULE14) reset request from the set alias
    assign sw_reset_start = set_wr && host_wdata[BIT_SOFTWARE_RESET];

    soft_reset_sequencer #(
        .CYCLES (SOFT_RESET_CYCLES)
    ) u_sw_reset (
        .clk   (clk),
        .reset (reset),
        .start (sw_reset_start),
        .busy  (sw_reset_busy)
    );

    // (RULE16) reads 1 while busy
    assign software_reset = sw_reset_busy;

    // (RULE14) internal state reset and FIFO flush for the whole window
    assign internal_state_reset = sw_reset_busy;
    assign fifo_flush           = sw_reset_busy;

    // (RULE15) only link registers see it; config space has no port here
    // Start edge included so the bits clear on the same edge that raises the busy flag
    assign regs_reset = reset || sw_reset_start || sw_reset_busy;

    // ************************************************************
    // Read/set/clear bit updates
    // ************************************************************
    // (RULE21) a 1 acts, a 0 leaves the bit
    always_comb begin
        enhance_next = enhancement_enable;
        power_next   = link_power_status;
        posted_next  = posted_write_enable_a;
        link_next    = link_enable_b;
        if (set_wr) begin
            enhance_next = enhance_next | host_wdata[BIT_ENHANCE_ENABLE];
            power_next   = power_next   | host_wdata[BIT_LINK_POWER_STATUS];
            posted_next  = posted_next  | host_wdata[BIT_POSTED_WRITE];
            link_next    = link_next    | host_wdata[BIT_LINK_ENABLE];
        end
        if (clr_wr) begin
            enhance_next = enhance_next & ~host_wdata[BIT_ENHANCE_ENABLE];
            power_next   = power_next   & ~host_wdata[BIT_LINK_POWER_STATUS];
            posted_next  = posted_next  & ~host_wdata[BIT_POSTED_WRITE];
            link_next    = link_next    & ~host_wdata[BIT_LINK_ENABLE];
        end
    end

    // Enhancement enable: software keeps it alone without permission.
    always_ff @(posedge clk) begin
        if (regs_reset) begin
            enhancement_enable <= RST_ENHANCE_ENABLE;
        end else begin
            enhancement_enable <= enhance_next;
        end
    end

    always_ff @(posedge clk) begin
        if (regs_reset) begin
            link_power_status <= RST_LINK_POWER_STATUS;
        end else begin
            link_power_status <= power_next;
        end
    end

    // Reset value is undefined in hardware; zero chosen for a known start.
    always_ff @(posedge clk) begin
        if (regs_reset) begin
            posted_write_enable_a <= RST_POSTED_WRITE;
        end else begin
            posted_write_enable_a <= posted_next;
        end
    end

    // (RULE11) cleared by hardware or software reset
    always_ff @(posedge clk) begin
        if (regs_reset) begin
            link_enable_b <= RST_LINK_ENABLE;
        end else begin
            link_enable_b <= link_next;
        end
    end

    // ************************************************************
    // Programming permission bit
    // ************************************************************
    // (RULE18) only the global reset input resets this one, back to its default 1
    // (RULE20) read-only, default 1, loaded from serial memory
    always_ff @(posedge clk) begin
        if (global_reset_input) begin
            phy_program_permission <= RST_PROGRAM_PERMISSION;
        end else if (permission_load) begin
            phy_program_permission <= permission_value;
        end
    end

    // ************************************************************
    // Effects on the link
    // ************************************************************
    // (RULE4) power status gates link-to-PHY traffic
    assign link_phy_comm_enable = link_power_status;

    // (RULE13) disconnected at once when link enable is low
    assign bus_connected = link_enable_b && !sw_reset_busy;

    // (RULE9) posting only while enabled
    assign posted_write_accept = posted_write_request && posted_write_enable_a;

    // ************************************************************
    // Read data assembly
    // ************************************************************
    // (RULE3) bits 21..20 stay zero
    // (RULE17) bits 15..0 stay zero
    always_comb begin
        ctrl_value                         = ZERO_DATA;
        ctrl_value[BIT_PROGRAM_PERMISSION] = phy_program_permission;
        ctrl_value[BIT_ENHANCE_ENABLE]     = enhancement_enable;
        ctrl_value[BIT_LINK_POWER_STATUS]  = link_power_status;
        ctrl_value[BIT_POSTED_WRITE]       = posted_write_enable_a;
        ctrl_value[BIT_LINK_ENABLE]        = link_enable_b;
        ctrl_value[BIT_SOFTWARE_RESET]     = sw_reset_busy;
    end

    // (RULE21) both aliases return the same value
    // (RULE6) all-ones answer when aborts are disabled
    always_comb begin
        read_next = ZERO_DATA;
        if (hit_set || hit_clr) begin
            read_next = ctrl_value;
        end else if (stopped_ones) begin
            read_next = ALL_ONES_DATA;
        end
    end

    // ************************************************************
    // Host answer, one cycle after the request
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            host_rdata    <= ZERO_DATA;
            host_rd_valid <= 1'b0;
        end else begin
            host_rd_valid <= host_rd && !stopped_abort;
            if (host_rd) begin
                host_rdata <= read_next;
            end
        end
    end

    // (RULE5) abort on reads and writes to a stopped PHY domain
    always_ff @(posedge clk) begin
        if (reset) begin
            host_target_abort <= 1'b0;
        end else begin
            host_target_abort <= (host_rd || host_wr) && stopped_abort;
        end
    end

endmodule : host_controller_control
`default_nettype wire

// File: rtl/hc_control_pkg.sv
// Constants shared by the host controller control register block
package hc_control_pkg;

    // ************************************************************
    // Register addresses (byte offsets on the host register port)
    // ************************************************************
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] CTRL_SET_OFFSET = 12'h050;
    localparam logic [11:0] CTRL_CLR_OFFSET = 12'h054;

    // ************************************************************
    // Address ranges that live in the PHY clock domain
    // ************************************************************
    localparam logic [11:0] PHY_RANGE_A_LO = 12'h0dc;
    localparam logic [11:0] PHY_RANGE_A_HI = 12'h0f0;
    localparam logic [11:0] PHY_RANGE_B_LO = 12'h100;
    localparam logic [11:0] PHY_RANGE_B_HI = 12'h11c;

    // ************************************************************
    // Field positions of the control register (bits 23..0)
    // ************************************************************
    localparam int BIT_PROGRAM_PERMISSION = 23;
    localparam int BIT_ENHANCE_ENABLE     = 22;
    localparam int BIT_LINK_POWER_STATUS  = 19;
    localparam int BIT_POSTED_WRITE       = 18;
    localparam int BIT_LINK_ENABLE        = 17;
    localparam int BIT_SOFTWARE_RESET     = 16;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic       RST_PROGRAM_PERMISSION = 1'b1;
    localparam logic       RST_ENHANCE_ENABLE     = 1'b0;
    localparam logic       RST_LINK_POWER_STATUS  = 1'b0;
    localparam logic       RST_POSTED_WRITE       = 1'b0;
    localparam logic       RST_LINK_ENABLE        = 1'b0;
    localparam logic [31:0] ALL_ONES_DATA         = 32'hffffffff;
    localparam logic [31:0] ZERO_DATA             = 32'h00000000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SOFT_RESET_CYCLES = 16;

endpackage : hc_control_pkg

// File: rtl/soft_reset_sequencer.sv
// Self-clearing software reset sequencer
`timescale 1ns/1ns
`default_nettype none
module soft_reset_sequencer #(
    parameter int CYCLES = hc_control_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      busy
);
    import hc_control_pkg::*;

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_reg;

    // ************************************************************
    // Busy window: holds for CYCLES clocks after the start
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            busy      <= 1'b0;
            count_reg <= '0;
        end else if (!busy && start) begin
            busy      <= 1'b1;
            count_reg <= '0;
        end else if (busy) begin
            if (count_reg == LAST) begin
                busy <= 1'b0;
            end
            count_reg <= count_reg + CNT_W'(1);
        end
    end

endmodule : soft_reset_sequencer
`default_nettype wire

// File: rtl/phy_domain_guard.sv
// Decides the answer to host accesses aimed at the PHY clock domain
`timescale 1ns/1ns
`default_nettype none
module phy_domain_guard (
    input  wire logic [11:0] addr,
    input  wire logic        phy_clock_running,
    input  wire logic        abort_disable,
    output logic             in_phy_domain,
    output logic             stopped_abort,
    output logic             stopped_ones
);
    import hc_control_pkg::*;

    logic stopped_hit;

    // ************************************************************
    // Range decode and stopped-clock answer
    // ************************************************************
    always_comb begin
        in_phy_domain = ((addr >= PHY_RANGE_A_LO) && (addr <= PHY_RANGE_A_HI))
                     || ((addr >= PHY_RANGE_B_LO) && (addr <= PHY_RANGE_B_HI));
        stopped_hit   = in_phy_domain && !phy_clock_running;
        stopped_abort = stopped_hit && !abort_disable;
        stopped_ones  = stopped_hit && abort_disable;
    end

endmodule : phy_domain_guard
`default_nettype wire

// File: dv/hc_control_monitor.sv
// Port checker for the host controller control register
`timescale 1ns/1ns
`default_nettype none
module hc_control_monitor
    import hc_control_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        global_reset_input,
    input wire logic [11:0] host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [31:0] host_wdata,
    input wire logic [31:0] host_rdata,
    input wire logic        host_rd_valid,
    input wire logic        host_target_abort,
    input wire logic        abort_disable,
    input wire logic        phy_clock_running,
    input wire logic        permission_load,
    input wire logic        posted_write_request,
    input wire logic        posted_write_accept,
    input wire logic        posted_write_enable_a,
    input wire logic        phy_program_permission,
    input wire logic        link_power_status,
    input wire logic        link_phy_comm_enable,
    input wire logic        link_enable_b,
    input wire logic        bus_connected,
    input wire logic        software_reset,
    input wire logic        fifo_flush
);
    // ********************************
    // Stopped PHY domain decode
    // ********************************
    wire logic in_phy = (host_addr >= PHY_RANGE_A_LO && host_addr <= PHY_RANGE_A_HI)
        || (host_addr >= PHY_RANGE_B_LO && host_addr <= PHY_RANGE_B_HI);
    wire logic stop_rd = host_rd && in_phy && !phy_clock_running;
    wire logic set_wr = host_wr && host_addr == CTRL_SET_OFFSET;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Only reads of this register; an all-ones answer elsewhere is legal
    property p_rsvd;
        host_rd_valid && $past(host_addr == CTRL_SET_OFFSET || host_addr == CTRL_CLR_OFFSET)
            |-> host_rdata[21:20] == 2'h0 && host_rdata[15:0] == 16'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_power;
        link_phy_comm_enable == link_power_status;
    endproperty
    a_power: assert property (p_power) else $error("phy traffic gate wrong");
    property p_abort;
        stop_rd && !abort_disable |=> host_target_abort && !host_rd_valid;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on stopped domain");
    property p_ones;
        stop_rd && abort_disable |=> host_rd_valid && host_rdata == 32'hffffffff;
    endproperty
    a_ones: assert property (p_ones) else $error("no all-ones answer");
    property p_pwa;
        posted_write_accept == (posted_write_request && posted_write_enable_a);
    endproperty
    a_pwa: assert property (p_pwa) else $error("posted write accept wrong");
    property p_srbusy;
        software_reset |-> fifo_flush && !link_enable_b && !bus_connected;
    endproperty
    a_srbusy: assert property (p_srbusy) else $error("soft reset effects missing");
    property p_srstart;
        set_wr && host_wdata[16] |=> software_reset;
    endproperty
    a_srstart: assert property (p_srstart) else $error("soft reset not started");
    property p_srend;
        $rose(software_reset) |-> ##[1:1000] !software_reset;
    endproperty
    a_srend: assert property (p_srend) else $error("soft reset never ends");
    property p_disc;
        !link_enable_b |-> !bus_connected;
    endproperty
    a_disc: assert property (p_disc) else $error("connected while link off");
    property p_set;
        set_wr && host_wdata[17:16] == 2'h2 && !software_reset |=> link_enable_b;
    endproperty
    a_set: assert property (p_set) else $error("set alias did not set");
    property p_perm;
        !global_reset_input && !permission_load |=> $stable(phy_program_permission);
    endproperty
    a_perm: assert property (p_perm) else $error("permission bit changed");
endmodule : hc_control_monitor
bind host_controller_control hc_control_monitor u_mon (.clk, .reset, .global_reset_input,
    .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_rd_valid,
    .host_target_abort, .abort_disable, .phy_clock_running, .permission_load,
    .posted_write_request, .posted_write_accept, .posted_write_enable_a,
    .phy_program_permission, .link_power_status, .link_phy_comm_enable, .link_enable_b,
    .bus_connected, .software_reset, .fifo_flush);
`default_nettype wire

// File: dv/host_sw_model.sv
// Host software model driving the register strobe port
`timescale 1ns/1ns
`default_nettype none
module host_sw_model (
    input  wire logic        clk,
    input  wire logic [31:0] host_rdata,
    input  wire logic        host_rd_valid,
    input  wire logic        host_target_abort,
    output logic      [11:0] host_addr,
    output logic             host_wr,
    output logic             host_rd,
    output logic      [31:0] host_wdata
);
    initial begin
        host_addr = 12'h000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 32'h00000000;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(posedge clk);
        #1;
        host_wr = 1'b0;
        // Stale data would hide a late sample
        host_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v,
                      output logic ab);
        @(posedge clk);
        #1;
        host_addr = a;
        host_rd = 1'b1;
        @(posedge clk);
        #1;
        host_rd = 1'b0;
        v = 1'b0;
        ab = 1'b0;
        d = 32'h00000000;
        repeat (2) begin
            if (host_rd_valid === 1'b1) begin
                v = 1'b1;
                d = host_rdata;
            end
            if (host_target_abort === 1'b1) ab = 1'b1;
            @(posedge clk);
            #1;
        end
    endtask : rd
endmodule : host_sw_model
`default_nettype wire

// File: dv/link_host_control_lower_bits_bench.sv
// Self-checking bench for the host controller control register
`timescale 1ns/1ns
`default_nettype none
module link_host_control_lower_bits_bench;
    import hc_control_pkg::*;
    logic clk = 1'b0, reset, global_reset_input, host_wr, host_rd, host_rd_valid;
    logic host_target_abort, abort_disable, phy_clock_running, permission_load;
    logic permission_value, posted_write_request, posted_write_accept;
    logic phy_program_permission, enhancement_enable, link_power_status;
    logic link_phy_comm_enable, posted_write_enable_a, link_enable_b, bus_connected;
    logic software_reset, internal_state_reset, fifo_flush;
    logic [11:0] host_addr;
    logic [31:0] host_wdata, host_rdata;
    int failures = 0, n_tests = 0;
    always #20 clk = ~clk;
    // Long enough that a read lands while still busy
    host_controller_control #(.SOFT_RESET_CYCLES(12)) DUT (.clk, .reset,
        .global_reset_input, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
        .host_rd_valid, .host_target_abort, .abort_disable, .phy_clock_running,
        .permission_load, .permission_value, .posted_write_request, .posted_write_accept,
        .phy_program_permission, .enhancement_enable, .link_power_status,
        .link_phy_comm_enable, .posted_write_enable_a, .link_enable_b, .bus_connected,
        .software_reset, .internal_state_reset, .fifo_flush);
    host_sw_model sw (.clk, .host_rdata, .host_rd_valid, .host_target_abort, .host_addr,
        .host_wr, .host_rd, .host_wdata);
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ev);
        logic [31:0] d;
        logic v, ab;
        sw.rd(a, d, v, ab);
        chk({v, ab, d}, {ev, ~ev, e});
    endtask : rchk
    task automatic t_defaults;
        rchk(CTRL_SET_OFFSET, 32'h00800000, 1'b1);
        rchk(CTRL_CLR_OFFSET, 32'h00800000, 1'b1);
    endtask : t_defaults
    task automatic t_setclr;
        sw.wr(CTRL_SET_OFFSET, 32'h00040000);
        // Reserved and read-only bits written as ones are ignored
        sw.wr(CTRL_SET_OFFSET, 32'hffbaffff);
        // settle time, shortened: the modelled PHY clock is steady at once
        repeat (250) @(posedge clk);
        sw.wr(CTRL_SET_OFFSET, 32'h00400000);
        posted_write_request = 1'b1;
        rchk(CTRL_CLR_OFFSET, 32'h00ce0000, 1'b1);
        chk({posted_write_accept, bus_connected, link_phy_comm_enable, enhancement_enable},
            4'hf);
        sw.wr(CTRL_CLR_OFFSET, 32'h00000000);
        sw.wr(CTRL_SET_OFFSET, 32'h00000000);
        rchk(CTRL_SET_OFFSET, 32'h00ce0000, 1'b1);
        sw.wr(CTRL_CLR_OFFSET, 32'h000a0000);
        chk({link_phy_comm_enable, bus_connected}, 2'h0);
        sw.wr(CTRL_CLR_OFFSET, 32'h00440000);
        chk(posted_write_accept, 1'b0);
        rchk(CTRL_SET_OFFSET, 32'h00800000, 1'b1);
        posted_write_request = 1'b0;
    endtask : t_setclr
    task automatic t_sreset;
        int n;
        sw.wr(CTRL_SET_OFFSET, 32'h000a0000);
        // settle time before the next access
        repeat (250) @(posedge clk);
        sw.wr(CTRL_SET_OFFSET, 32'h00400000);
        sw.wr(CTRL_SET_OFFSET, 32'h00010000);
        rchk(CTRL_CLR_OFFSET, 32'h00810000, 1'b1);
        chk({fifo_flush, internal_state_reset, bus_connected}, 3'h6);
        // Ignored while busy
        sw.wr(CTRL_SET_OFFSET, 32'h00020000);
        n = 0;
        while (software_reset !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        #1;
        rchk(CTRL_SET_OFFSET, 32'h00800000, 1'b1);
    endtask : t_sreset
    task automatic t_phy;
        logic [11:0] a[7] = '{12'h0d8, 12'h0dc, 12'h0f0, 12'h0f4, 12'h100, 12'h11c, 12'h120};
        logic ins[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 4; k++) begin
            abort_disable = k[0];
            phy_clock_running = k[1];
            for (int i = 0; i < 7; i++) begin
                if (ins[i] && !k[1]) rchk(a[i], {32{k[0]}}, k[0]);
                else rchk(a[i], 32'h00000000, 1'b1);
            end
        end
    endtask : t_phy
    task automatic t_perm;
        @(posedge clk);
        #1;
        permission_value = 1'b0;
        permission_load = 1'b1;
        @(posedge clk);
        #1;
        permission_load = 1'b0;
        sw.wr(CTRL_SET_OFFSET, 32'h00820000); // bit 22 left alone
        rchk(CTRL_SET_OFFSET, 32'h00020000, 1'b1);
        reset = 1'b1;
        @(posedge clk);
        #1;
        reset = 1'b0;
        rchk(CTRL_SET_OFFSET, 32'h00000000, 1'b1);
        global_reset_input = 1'b1;
        @(posedge clk);
        #1;
        global_reset_input = 1'b0;
        rchk(CTRL_SET_OFFSET, 32'h00800000, 1'b1);
    endtask : t_perm
    task automatic end_sim;
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        reset = 1'b1;
        global_reset_input = 1'b1;
        abort_disable = 1'b0;
        phy_clock_running = 1'b1;
        permission_load = 1'b0;
        permission_value = 1'b1;
        posted_write_request = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        global_reset_input = 1'b0;
        t_defaults;
        t_setclr;
        t_sreset;
        t_phy;
        phy_clock_running = 1'b1;
        t_perm;
        end_sim;
    end
    initial begin
        #400000;
        failures++;
        end_sim;
    end
endmodule : link_host_control_lower_bits_bench
`default_nettype wire
